/* rtl/pmr_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 125 MHz hclk, AHB-Lite word registers
// Notes:   Offsets are register indices; byte address is index times four
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH
// ****************************************
// Register indices
// ****************************************
`define PMR_IDX_CONFIG      6'h00
`define PMR_IDX_ADC_CONFIG  6'h01
`define PMR_IDX_STATUS      6'h02
`define PMR_IDX_MASK        6'h03
`define PMR_IDX_BUS_VOLTAGE_RESULT_RES    6'h05
`define PMR_IDX_TEMP_RES    6'h06
`define PMR_IDX_CURR_RES    6'h07
`define PMR_IDX_POWER_RES   6'h08
`define PMR_IDX_ENERGY_LO   6'h09
`define PMR_IDX_CHARGE_LO   6'h0a
`define PMR_IDX_ENERGY_HI   6'h19
`define PMR_IDX_CHARGE_HI   6'h1a
`define PMR_IDX_DEVICE_ID   6'h3e
// ****************************************
// Fields
// ****************************************
`define PMR_CFG_ACC_CLEAR   0
`define PMR_CFG_RUN         1
`define PMR_ADC_CT_LSB      0
`define PMR_ADC_AVG_LSB     4
`define PMR_ST_CHARGE_OF    0
`define PMR_ST_READY        1
`define PMR_CFG_RESET       32'h0000_0002
`define PMR_ADC_RESET       32'h0000_0017
`define PMR_DEVICE_ID       16'h0a5c // Arbitrary value
// ****************************************
// Timing
// ****************************************
`define PMR_CLK_MHZ         125
`define PMR_CT_US_LIST      '{50, 84, 150, 280, 540, 1052, 2074, 4120}
`endif

/* rtl/pmr_pkg.sv */
// Purpose: Types shared by the power monitor result block
// Assumes: Nothing beyond the constants header
// Notes:   Scales are in comments beside the fields
package pmr_pkg;
   // ****************************************
   // Sample from the converter front end
   // ****************************************
   typedef struct packed {
      logic signed [19:0] current;   // 75 uA per code
      logic signed [19:0] bus_voltage_result;      // 195.3125 uV per code, may be negative; result clamps to zero
      logic signed [15:0] temp;      // 7.8125 m-degC per code
   } pmr_sample_t;
   typedef struct packed {
      logic [2:0] conv_time;
      logic [2:0] avg_sel;
   } pmr_adc_t;
   typedef enum logic [1:0] {
      PMR_PH_TEMP,
      PMR_PH_CURR,
      PMR_PH_BUS_VOLTAGE_RESULT
   } pmr_phase_t;
endpackage

/* rtl/pmr_result_regs.sv */
// Purpose: Result registers, accumulators and conversion sequencing
// Assumes: Converter front end delivers raw codes; AHB-Lite register access
// Notes:   Interrupt high while any unmasked status bit is set
//
// How it works
// - Current result is 20-bit signed, 75 uA per code.
// - Bus voltage is 20-bit signed field, never negative, 195.3125 uV step.
// - Bus voltage coding spans 102.4 V though silicon stops at 85 V.
// - Die temperature is 16-bit signed, 7.8125 m-degC per code.
// - Power 24-bit unsigned; energy and charge 40-bit unsigned.
// - Signed fields use two's complement.
// - Energy accumulator wraps to zero on overflow, no flag.
// - Writing one to accumulator clear zeroes energy at any time.
// - Charge overflow sets the sticky charge overflow flag.
// - Eight conversion times from 50 us to 4120 us.
// - Averaging counts of 1, 4, 16 and more samples.
// - One result every conversion time times averaging count.
// - After reset, converts temperature, current, bus voltage continuously.
`timescale 1ns/1ps
`include "pmr_regs.svh"
module pmr_result_regs #(
   parameter int AVG_MAX_LOG = 10
) (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire pmr_pkg::pmr_sample_t adc_sample,
   output logic                      irq
);
   import pmr_pkg::*;

   // ****************************************
   // Timing table
   // ****************************************
   localparam int CT_US [8] = `PMR_CT_US_LIST;
   function automatic logic [19:0] ct_cycles(input logic [2:0] sel);
      ct_cycles = 20'(CT_US[sel] * `PMR_CLK_MHZ);
   endfunction
   // One conversion time covers all three channel slots, so the result
   // rate is the conversion time times the averaging count
   function automatic logic [19:0] slot_cycles(input logic [2:0] sel);
      slot_cycles = 20'((CT_US[sel] * `PMR_CLK_MHZ) / 3);
   endfunction

   // ****************************************
   // Bus address phase capture
   // ****************************************
   logic        ap_wr;
   logic        ap_rd;
   logic [5:0]  ap_idx;
   wire         take   = hsel & hready & htrans[1];
   wire  [5:0]  idx_in = haddr[7:2];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr  <= 1'b0;
         ap_rd  <= 1'b0;
         ap_idx <= 6'h00;
      end else begin
         ap_wr  <= take & hwrite;
         ap_rd  <= take & ~hwrite;
         ap_idx <= idx_in;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   logic [31:0] cfg;
   logic [31:0] adc_cfg;
   logic [1:0]  status;
   logic [1:0]  mask;
   wire  wr_cfg  = ap_wr & (ap_idx == `PMR_IDX_CONFIG);
   wire  wr_adc  = ap_wr & (ap_idx == `PMR_IDX_ADC_CONFIG);
   wire  wr_stat = ap_wr & (ap_idx == `PMR_IDX_STATUS);
   wire  wr_mask = ap_wr & (ap_idx == `PMR_IDX_MASK);
   // Clear bit is a self-clearing strobe, never stored
   wire  acc_clear = wr_cfg & hwdata[`PMR_CFG_ACC_CLEAR];
   wire  run       = cfg[`PMR_CFG_RUN];
   pmr_adc_t adc;
   assign adc.conv_time = adc_cfg[`PMR_ADC_CT_LSB +: 3];
   assign adc.avg_sel   = adc_cfg[`PMR_ADC_AVG_LSB +: 3];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg     <= `PMR_CFG_RESET;
         adc_cfg <= `PMR_ADC_RESET;
         mask    <= 2'h0;
      end else begin
         if (wr_cfg)
            cfg <= {30'h0, hwdata[`PMR_CFG_RUN], 1'b0};
         if (wr_adc)
            adc_cfg <= {25'h0, hwdata[6:4], 1'b0, hwdata[2:0]};
         if (wr_mask)
            mask <= hwdata[1:0];
      end
   end

   // ****************************************
   // Conversion sequencer
   // ****************************************
   pmr_phase_t  phase;
   pmr_phase_t  next_phase;
   logic [19:0] tick_cnt;
   logic [10:0] avg_cnt;
   wire  [3:0]  avg_log  = (adc.avg_sel == 3'h0) ? 4'h0 :
                           (adc.avg_sel > 3'h5)  ? 4'(AVG_MAX_LOG) :
                           {adc.avg_sel, 1'b0};
   wire  [10:0] avg_len  = 11'h1 << avg_log;
   wire         last_ph  = phase == PMR_PH_BUS_VOLTAGE_RESULT;
   // Last slot takes the remainder of the split, so a round is exact
   wire  [19:0] ct_full  = ct_cycles(adc.conv_time);
   wire  [19:0] slot_a   = slot_cycles(adc.conv_time);
   wire  [19:0] slot_len = last_ph ? ct_full - {slot_a[18:0], 1'b0}
                                   : slot_a;
   wire         conv_end = run & (tick_cnt >= slot_len - 20'h1);
   wire         avg_done = conv_end & last_ph & (avg_cnt >= avg_len - 11'h1);

   always_comb begin
      next_phase = phase;
      unique case (phase)
         PMR_PH_TEMP: next_phase = PMR_PH_CURR;
         PMR_PH_CURR: next_phase = PMR_PH_BUS_VOLTAGE_RESULT;
         PMR_PH_BUS_VOLTAGE_RESULT: next_phase = PMR_PH_TEMP;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase    <= PMR_PH_TEMP;
         tick_cnt <= 20'h0;
         avg_cnt  <= 11'h0;
      end else if (run) begin
         tick_cnt <= conv_end ? 20'h0 : tick_cnt + 20'h1;
         if (conv_end)
            phase <= next_phase;
         if (avg_done)
            avg_cnt <= 11'h0;
         else if (conv_end & last_ph)
            avg_cnt <= avg_cnt + 11'h1;
      end
   end

   // ****************************************
   // Averaging sums, one per channel
   // ****************************************
   // Sums are wide enough for 1024 samples, so no saturation is needed
   logic [2:0][29:0] raw_ext;
   wire              first = avg_cnt == 11'h0;
   wire  [3:0]       shift = avg_log;
   // Slot order of the sequencer: temperature, current, bus voltage
   assign raw_ext = {30'(adc_sample.bus_voltage_result), 30'(adc_sample.current),
                     30'(adc_sample.temp)};

   generate
      for (genvar ch = 0; ch < 3; ch++) begin : g_sum
         logic signed [29:0] acc;
         wire                hit = conv_end & (phase == pmr_phase_t'(ch));
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               acc <= 30'sh0;
            else if (hit)
               acc <= (first ? 30'sh0 : acc) + $signed(raw_ext[ch]);
         end
      end
   endgenerate
   wire signed [29:0] sum_temp = g_sum[0].acc;
   wire signed [29:0] sum_curr = g_sum[1].acc;
   wire signed [29:0] sum_bus_voltage_result = g_sum[2].acc;

   // ****************************************
   // Results and accumulators
   // ****************************************
   logic signed [19:0] curr_res;
   logic signed [19:0] bus_voltage_result_res;
   logic signed [15:0] temp_res;
   logic        [23:0] power_res;
   logic        [39:0] energy;
   logic        [39:0] charge;
   // The bus voltage slot closes the round, so its newest code joins here;
   // a stale sum from the previous round must not leak into a first sample
   wire  signed [29:0] bus_voltage_result_sum_n = (first ? 30'sh0 : sum_bus_voltage_result)
                                    + $signed(raw_ext[2]);
   wire  signed [19:0] next_curr  = 20'(sum_curr >>> shift);
   wire  signed [19:0] bus_voltage_result_avg   = 20'(bus_voltage_result_sum_n >>> shift);
   // Negative bus readings are noise near zero; clamp keeps the field positive
   wire  signed [19:0] next_bus_voltage_result  = bus_voltage_result_avg[19] ? 20'sh0 : bus_voltage_result_avg;
   wire         [19:0] curr_mag   = next_curr[19] ? 20'(-next_curr)
                                                  : next_curr;
   // 75 uA x 195.3125 uV = 14.65 nW; 240 uW / that = 2^14
   wire         [38:0] pwr_prod   = 39'(curr_mag) * 39'(next_bus_voltage_result);
   wire         [23:0] next_power = 24'(pwr_prod >> 14);
   // Energy per result: power x 1 count (one 240 uW step per power code)
   wire         [40:0] next_energy = 41'(energy) + 41'(next_power);
   wire         [40:0] next_charge = 41'(charge) + 41'(curr_mag);
   wire         charge_of = avg_done & next_charge[40];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         curr_res  <= 20'sh0;
         bus_voltage_result_res  <= 20'sh0;
         temp_res  <= 16'sh0;
         power_res <= 24'h0;
      end else if (avg_done) begin
         curr_res  <= next_curr;
         bus_voltage_result_res  <= next_bus_voltage_result;
         temp_res  <= 16'(sum_temp >>> shift);
         power_res <= next_power;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         energy <= 40'h0;
         charge <= 40'h0;
      end else if (acc_clear) begin
         energy <= 40'h0;
         charge <= 40'h0;
      end else if (avg_done) begin
         energy <= next_energy[39:0];
         charge <= next_charge[39:0];
      end
   end

   // ****************************************
   // Status, mask and interrupt
   // ****************************************
   // Hardware set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= 2'h0;
      end else begin
         status[`PMR_ST_CHARGE_OF] <= charge_of |
            (status[`PMR_ST_CHARGE_OF] &
             ~(wr_stat & hwdata[`PMR_ST_CHARGE_OF]));
         status[`PMR_ST_READY] <= avg_done |
            (status[`PMR_ST_READY] & ~(wr_stat & hwdata[`PMR_ST_READY]));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(status & mask);
   end

   // ****************************************
   // Read path with snapshot of upper words
   // ****************************************
   // Reading a low word latches its upper byte, so high reads stay coherent
   logic [7:0] energy_hi;
   logic [7:0] charge_hi;
   wire  [31:0] rd_mux;

   // ****************************************
   // Read select
   // ****************************************
   wire  sel_cfg  = idx_in == `PMR_IDX_CONFIG;
   wire  sel_adc  = idx_in == `PMR_IDX_ADC_CONFIG;
   wire  sel_stat = idx_in == `PMR_IDX_STATUS;
   wire  sel_mask = idx_in == `PMR_IDX_MASK;
   wire  sel_bus_voltage_result = idx_in == `PMR_IDX_BUS_VOLTAGE_RESULT_RES;
   wire  sel_temp = idx_in == `PMR_IDX_TEMP_RES;
   wire  sel_curr = idx_in == `PMR_IDX_CURR_RES;
   wire  sel_pwr  = idx_in == `PMR_IDX_POWER_RES;
   wire  sel_e_lo = idx_in == `PMR_IDX_ENERGY_LO;
   wire  sel_c_lo = idx_in == `PMR_IDX_CHARGE_LO;
   wire  sel_e_hi = idx_in == `PMR_IDX_ENERGY_HI;
   wire  sel_c_hi = idx_in == `PMR_IDX_CHARGE_HI;
   wire  sel_id   = idx_in == `PMR_IDX_DEVICE_ID;
   wire  rd_e_lo  = take & ~hwrite & sel_e_lo;
   wire  rd_c_lo  = take & ~hwrite & sel_c_lo;

   // Unmapped indices select nothing and read as zero
   assign rd_mux = ({32{sel_cfg}}  & cfg)
                 | ({32{sel_adc}}  & adc_cfg)
                 | ({32{sel_stat}} & {30'h0, status})
                 | ({32{sel_mask}} & {30'h0, mask})
                 | ({32{sel_bus_voltage_result}} & {12'h0, bus_voltage_result_res})
                 | ({32{sel_temp}} & {16'h0, temp_res})
                 | ({32{sel_curr}} & {12'h0, curr_res})
                 | ({32{sel_pwr}}  & {8'h0, power_res})
                 | ({32{sel_e_lo}} & energy[31:0])
                 | ({32{sel_c_lo}} & charge[31:0])
                 | ({32{sel_e_hi}} & {24'h0, energy_hi})
                 | ({32{sel_c_hi}} & {24'h0, charge_hi})
                 | ({32{sel_id}}   & {16'h0, `PMR_DEVICE_ID});

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0;
         energy_hi <= 8'h0;
         charge_hi <= 8'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hrdata    <= (take & ~hwrite) ? rd_mux : 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (rd_e_lo)
            energy_hi <= energy[39:32];
         if (rd_c_lo)
            charge_hi <= charge[39:32];
      end
   end
endmodule

/* sim/pmr_result_regs_assertions.sv */
// Purpose: Port checks for the power monitor result registers
// Assumes: Zero wait-state AHB-Lite slave, index = haddr[7:2]
// Notes:   Helper flops track the data phase of each transfer
`timescale 1ns/1ps
`include "pmr_regs.svh"
module pmr_result_regs_assertions (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        irq
);
   // ****************************************
   // Data phase tracking
   // ****************************************
   logic        rd_dp;
   logic        wr_dp;
   logic [5:0]  idx_q;
   logic [31:0] mask_q;
   wire         take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_dp <= 1'b0;
         wr_dp <= 1'b0;
         idx_q <= 6'h00;
      end else begin
         rd_dp <= take & ~hwrite;
         wr_dp <= take & hwrite;
         idx_q <= haddr[7:2];
      end
   end
   // Shadow of the mask, updated where the slave takes write data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= 32'h0;
      end else if (wr_dp && idx_q == `PMR_IDX_MASK) begin
         mask_q <= hwdata;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_const_a:
   assert property (hreadyout) else $error("hreadyout low");
   okay_resp_a:
   assert property (!hresp) else $error("hresp not okay");
   rdata_idle_a:
   assert property (!rd_dp |-> hrdata == 32'h0)
      else $error("hrdata not zero outside read");
   ident_read_a:
   assert property (rd_dp && idx_q == `PMR_IDX_DEVICE_ID
      |-> hrdata[15:0] == `PMR_DEVICE_ID) else $error("bad id");
   unmapped_read_a:
   assert property (rd_dp && idx_q == 6'h04 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   clear_strobe_a:
   assert property (rd_dp && idx_q == `PMR_IDX_CONFIG
      |-> !hrdata[`PMR_CFG_ACC_CLEAR]) else $error("clear bit reads one");
   bus_voltage_result_sign_a:
   assert property (rd_dp && idx_q == `PMR_IDX_BUS_VOLTAGE_RESULT_RES |-> !hrdata[19])
      else $error("bus voltage negative");
   mask_off_a:
   assert property (mask_q == 32'h0 && $past(mask_q) == 32'h0 |-> !irq)
      else $error("irq with mask clear");
   mask_drop_a:
   assert property (wr_dp && idx_q == `PMR_IDX_MASK && hwdata == 32'h0
      |-> ##[1:2] !irq) else $error("irq stays after mask clear");
endmodule
bind pmr_result_regs pmr_result_regs_assertions chk_u (.hclk, .hresetn,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
   .hresp, .irq);

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the result register block
// Assumes: Zero wait states; conv_time 0 with one sample shortens runs
// Notes:   Reads queue their expectation; a monitor compares them
`timescale 1ns/1ps
`include "pmr_regs.svh"
module tb_top;
   import pmr_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready;
   logic        hreadyout, hresp, irq;
   logic        dp = 1'b0;
   logic [31:0] haddr, hwdata, hrdata, pw, e_v, m_v;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] lfsr, r1, r2, tv;
   logic [19:0] cv, vv, av;
   pmr_sample_t smp;
   logic [31:0] exq[$];
   logic [31:0] mkq[$];
   int          err_count, comparisons, n;
   assign hready = hreadyout;
   pmr_result_regs dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
      .adc_sample(smp), .irq);
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   task automatic fail(input string m);
      err_count++;
      $display("Error at %0t: %s", $time, m);
   endtask
   task automatic close_out();
      $display("Counts: %0d compares, %0d errors", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Holds the request until hready is seen high, then the data phase
   task automatic xfer(input logic w, input logic [5:0] i,
                       input logic [31:0] d, e, m);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, i, 2'b00};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      if (!w) begin
         exq.push_back(e);
         mkq.push_back(m);
      end
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask
   task automatic rd(input logic [5:0] i, input logic [31:0] e, m);
      xfer(1'b0, i, 32'h0, e, m);
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      xfer(1'b1, i, d, 32'h0, 32'h0);
   endtask
   // A zero mask marks a raw read that is not compared
   always @(posedge hclk) begin
      if (dp && mkq.size() > 0) begin
         e_v = exq.pop_front();
         m_v = mkq.pop_front();
         if (m_v !== 32'h0) begin
            comparisons++;
            if ((hrdata & m_v) !== (e_v & m_v)) fail("read data mismatch");
         end
      end
      dp = hsel && htrans[1] && !hwrite && hreadyout;
   end
   initial begin
      repeat (90000) @(posedge hclk);
      fail("watchdog expired");
      close_out();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      smp = '0;
      lfsr = 16'h0032;
      err_count = 0;
      comparisons = 0;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`PMR_IDX_CONFIG, `PMR_CFG_RESET, 32'hffffffff);
      rd(`PMR_IDX_ADC_CONFIG, `PMR_ADC_RESET, 32'h77);
      rd(`PMR_IDX_MASK, 32'h0, 32'hffffffff);
      wr(`PMR_IDX_DEVICE_ID, 32'h0);
      rd(`PMR_IDX_DEVICE_ID, {16'h0, `PMR_DEVICE_ID}, 32'hffff);
      rd(6'h04, 32'h0, 32'hffffffff);
      for (int k = 0; k < 8; k++) begin
         wr(`PMR_IDX_ADC_CONFIG, 32'(k * 17));
         rd(`PMR_IDX_ADC_CONFIG, 32'(k * 17), 32'h77);
      end
      wr(`PMR_IDX_ADC_CONFIG, 32'h0);
      $display("test registers done");
      for (int it = 0; it < 2; it++) begin
         r1 = rnd();
         r2 = rnd();
         cv = {~it[0], r1, r2[2:0]};
         vv = {~it[0], r2[15:3], r1[5:0]};
         tv = r1 ^ r2;
         av = cv[19] ? (~cv + 20'h1) : cv;
         // Power step is 2^14 current-times-voltage steps
         pw = 32'((40'(av) * 40'(it ? vv : 20'h0)) >> 14);
         smp <= {cv, vv, tv};
         wr(`PMR_IDX_CONFIG, 32'h0);
         wr(`PMR_IDX_MASK, 32'h2);
         wr(`PMR_IDX_CONFIG, 32'h3);
         wr(`PMR_IDX_STATUS, 32'h3);
         rd(`PMR_IDX_ENERGY_LO, 32'h0, 32'hffffffff);
         rd(`PMR_IDX_CHARGE_LO, 32'h0, 32'hffffffff);
         n = 0;
         // One result per 6250-cycle round at 50 us and one sample
         while (irq !== 1'b1 && n < 6400) begin
            @(posedge hclk);
            n++;
         end
         comparisons++;
         if (irq !== 1'b1 || n < 6000) fail("result period wrong");
         rd(`PMR_IDX_CURR_RES, {12'h0, cv}, 32'hfffff);
         rd(`PMR_IDX_BUS_VOLTAGE_RESULT_RES, {12'h0, it ? vv : 20'h0}, 32'hfffff);
         rd(`PMR_IDX_TEMP_RES, {16'h0, tv}, 32'hffff);
         rd(`PMR_IDX_CHARGE_LO, {12'h0, av}, 32'hffffffff);
         rd(`PMR_IDX_CHARGE_HI, 32'h0, 32'hff);
         rd(`PMR_IDX_POWER_RES, {8'h0, pw[23:0]}, 32'hffffffff);
         rd(`PMR_IDX_ENERGY_LO, {8'h0, pw[23:0]}, 32'hffffffff);
         rd(`PMR_IDX_ENERGY_HI, 32'h0, 32'hff);
         rd(`PMR_IDX_STATUS, 32'h2, 32'h3);
         wr(`PMR_IDX_STATUS, 32'h2);
         repeat (2) @(posedge hclk);
         comparisons++;
         if (irq !== 1'b0) fail("irq stays after status clear");
         $display("test result %0d done", it);
      end
      wr(`PMR_IDX_MASK, 32'h0);
      repeat (4) @(posedge hclk);
      close_out();
   end
endmodule
